// File: include/arf_pkg.sv
// Package with constants for the asynchronous receive request formatter
package arf_pkg;

  // Transaction codes
  localparam logic [3:0] TC_QWRITE_REQ = 4'h0;
  localparam logic [3:0] TC_BWRITE_REQ = 4'h1;
  localparam logic [3:0] TC_WRITE_RESP = 4'h2;
  localparam logic [3:0] TC_QREAD_REQ = 4'h4;
  localparam logic [3:0] TC_BREAD_REQ = 4'h5;
  localparam logic [3:0] TC_QREAD_RESP = 4'h6;
  localparam logic [3:0] TC_BREAD_RESP = 4'h7;
  localparam logic [3:0] TC_LOCK_REQ = 4'h9;
  localparam logic [3:0] TC_LOCK_RESP = 4'hB;
  localparam logic [3:0] TC_PHY = 4'hE;

  // Header field positions in the first quadlet
  localparam int TCODE_LSB = 4;
  localparam int TCODE_W = 4;
  localparam int TARGET_ID_LSB = 16;
  localparam int TARGET_ID_W = 16;
  localparam int LABEL_LSB = 10;
  localparam int LABEL_W = 6;
  localparam int RETRY_LSB = 8;
  localparam int RETRY_W = 2;
  localparam int HDR_RSVD_LSB = 0;
  localparam int HDR_RSVD_W = 4;

  // Body quadlet field positions
  localparam int HALF_W = 16;
  localparam int RESP_CODE_LSB = 12;
  localparam int RESP_CODE_W = 4;

  // Layout classes
  typedef enum logic [1:0] {
    ARF_FMT_NODATA = 2'b00,
    ARF_FMT_QUAD = 2'b01,
    ARF_FMT_BLOCK = 2'b11,
    ARF_FMT_PHY = 2'b10
  } arf_fmt_e;

  // Quadlet counts before the payload/trailer
  localparam logic [2:0] HDR_QUADS_NODATA = 3'h3;
  localparam logic [2:0] HDR_QUADS_QUAD = 3'h4;
  localparam logic [2:0] HDR_QUADS_BLOCK = 3'h4;
  localparam logic [2:0] HDR_QUADS_PHY = 3'h3;

  // Quadlet positions inside a packet
  localparam logic [2:0] QIDX_BODY_FIRST = 3'h1;
  localparam logic [2:0] QIDX_SENDER = 3'h1;
  localparam logic [2:0] QIDX_OFFSET_LOWER = 3'h2;
  localparam logic [2:0] QIDX_FOURTH = 3'h3;
  localparam logic [2:0] QIDX_PHY_DATA = 3'h1;
  localparam logic [2:0] QIDX_PHY_INV = 3'h2;
  localparam logic [2:0] QIDX_MAX = 3'h7;
  localparam logic [2:0] QIDX_STEP = 3'h1;

  // Synthesized PHY header around its code
  localparam logic [23:0] PHY_HDR_FILL = 24'h00_0000;
  localparam logic [3:0] PHY_HDR_LOW = 4'h0;

  localparam int SECONDS_KEEP_W = 3;
  localparam int CYCLE_INDEX_W = 13;
  localparam int BYTE_COUNT_LSB = 16;

endpackage

// File: sim/arf_formatter_checker.sv
// Assertion checker for the receive formatter ports
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module arf_formatter_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic i_rx_phy,
  input wire logic o_rx_ready,
  input wire logic [15:0] i_dma_channel_control,
  input wire logic o_buf_valid,
  input wire logic [31:0] o_buf_data,
  input wire logic o_buf_first,
  input wire logic o_buf_last,
  input wire logic o_pkt_dropped
);
  wire logic take = i_rx_valid && o_rx_ready;
  wire logic [3:0] tc = i_rx_data[7:4];
  wire logic bad = !i_rx_phy && !(tc inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB});
  logic mid_q;
  logic drop_q;
  // Tracks packet position so header-only rules skip body quadlets
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mid_q <= 1'h0;
      drop_q <= 1'h0;
    end else if (take) begin
      mid_q <= !i_rx_last;
      drop_q <= mid_q ? drop_q : bad;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_drop; take && !mid_q && bad |=> o_pkt_dropped && !o_buf_valid; endproperty
  a_drop: assert property (p_drop) else $error("bad code not dropped");
  property p_quiet; take && mid_q && drop_q |=> !o_buf_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("dropped packet written");
  property p_hdr; take && !mid_q && !bad && !i_rx_phy |=> o_buf_first && o_buf_data == $past(i_rx_data); endproperty
  a_hdr: assert property (p_hdr) else $error("header not copied");
  property p_body; take && mid_q && !drop_q |=> o_buf_valid && !o_buf_first && o_buf_data == $past(i_rx_data); endproperty
  a_body: assert property (p_body) else $error("body quadlet wrong");
  property p_trail; take && i_rx_last && mid_q && !drop_q |=> o_buf_valid ##1 o_buf_valid && o_buf_last; endproperty
  a_trail: assert property (p_trail) else $error("trailer misplaced");
  property p_gap; take && i_rx_last && mid_q && !drop_q |=> !o_rx_ready ##1 o_rx_ready; endproperty
  a_gap: assert property (p_gap) else $error("ready gap wrong");
  property p_phy; take && !mid_q && i_rx_phy |=> o_buf_first && o_buf_data == 32'h0000_00E0 ##1 o_buf_data == $past(i_rx_data, 2) ##1 o_buf_data == ~$past(i_rx_data, 3) ##1 o_buf_last; endproperty
  a_phy: assert property (p_phy) else $error("phy layout wrong");
  property p_stat; o_buf_last |-> o_buf_valid && o_buf_data[31:16] == i_dma_channel_control; endproperty
  a_stat: assert property (p_stat) else $error("status word wrong");
  property p_flags; o_buf_first |-> o_buf_valid && !o_buf_last; endproperty
  a_flags: assert property (p_flags) else $error("first flag wrong");
  c_phy: cover property (take && i_rx_phy);
  c_drop: cover property (o_pkt_dropped);
  c_blk: cover property (take && !mid_q && tc == 4'h1);
endmodule // arf_formatter_checker
bind arf_formatter arf_formatter_checker arf_formatter_checker_inst (.i_clk, .i_rst_n,
  .i_rx_valid, .i_rx_data, .i_rx_last, .i_rx_phy, .o_rx_ready, .i_dma_channel_control,
  .o_buf_valid, .o_buf_data, .o_buf_first, .o_buf_last, .o_pkt_dropped);
`default_nettype wire

// File: sim/arf_link_model.sv
// Link receive path model feeding quadlets from a queue
`timescale 1ns/1ps
`default_nettype none
// ====
// Link model
module arf_link_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_data,
  output logic o_last,
  output logic o_phy
);
  logic [33:0] q[$];
  logic took = 1'h0;
  initial {o_valid, o_data, o_last, o_phy} = 35'h0;
  always @(posedge i_clk) took <= o_valid & i_ready;
  // Holds each quadlet until taken; idle data toggles so stale values never match
  always @(negedge i_clk) begin
    if (took && q.size() > 0) void'(q.pop_front());
    o_valid = q.size() > 0;
    if (o_valid) {o_phy, o_last, o_data} = q[0];
    else {o_phy, o_last, o_data} = {2'h0, ~o_data};
  end
endmodule // arf_link_model
`default_nettype wire

// File: sim/async_receive_request_formatter_bench.sv
// Testbench for the receive formatter
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module async_receive_request_formatter_bench;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic v, l, p, rdy, bv, bf, bl, dr;
  logic [31:0] d, bd;
  logic [15:0] ctl = 16'h8011;
  logic [6:0] sec = 7'h0D;
  logic [12:0] cyc = 13'h1ABC;
  int n_errors = 0;
  int tests_run = 0;
  int drops = 0;
  logic [31:0] got[$];
  always #20 i_clk = ~i_clk;
  arf_link_model arf_link_model_inst (.i_clk, .i_ready(rdy), .o_valid(v), .o_data(d),
    .o_last(l), .o_phy(p));
  arf_formatter arf_formatter_inst (.i_clk, .i_rst_n, .i_rx_valid(v), .i_rx_data(d),
    .i_rx_last(l), .i_rx_phy(p), .o_rx_ready(rdy), .i_dma_channel_control(ctl),
    .i_bus_seconds_count(sec), .i_bus_cycle_index(cyc), .o_buf_valid(bv), .o_buf_data(bd),
    .o_buf_first(bf), .o_buf_last(bl), .o_pkt_dropped(dr));
  always @(negedge i_clk) begin
    if (bv) got.push_back(bd);
    if (dr) drops++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] trl();
    return {ctl, sec[2:0], cyc};
  endfunction
  task automatic xfer(input logic [31:0] pk[$], input logic ph, input int n);
    got.delete();
    drops = 0;
    foreach (pk[i]) arf_link_model_inst.q.push_back({ph, i == pk.size() - 1, pk[i]});
    for (int k = 0; k < 60 && got.size() < n; k++) @(negedge i_clk);
    repeat (4) @(negedge i_clk);
  endtask
  task automatic plain(input logic [3:0] tc, input int nb);
    logic [31:0] pk[$];
    pk.push_back({16'hFFC2, 6'h2A, tc[1:0], tc, 4'h5});
    for (int i = 0; i < nb; i++) pk.push_back({tc, 28'(i) ^ 28'h5A5_A5A5});
    xfer(pk, 1'h0, nb + 2);
    pk.push_back(trl());
    chk("count", 32'(pk.size()), 32'(got.size()));
    foreach (pk[i]) chk("quadlet", pk[i], got[i]);
  endtask
  task automatic t_qread(); plain(4'h4, 2); endtask
  task automatic t_qwrite(); plain(4'h0, 3); endtask
  task automatic t_bread(); plain(4'h5, 3); endtask
  task automatic t_block(); plain(4'h1, 5); endtask
  task automatic t_lock(); plain(4'h9, 4); endtask
  task automatic t_resp();
    logic [3:0] rc[4] = '{4'h2, 4'h6, 4'h7, 4'hB};
    foreach (rc[i]) plain(rc[i], 3);
  endtask
  task automatic t_drop();
    logic [3:0] bc[7] = '{4'h3, 4'h8, 4'hA, 4'hC, 4'hD, 4'hF, 4'hE};
    foreach (bc[i]) begin
      xfer('{{16'hFFFF, 8'h04, bc[i], 4'h0}, 32'h0000_0001}, 1'h0, 0);
      chk("dropped", 32'h1, 32'(drops));
      chk("count", 32'h0, 32'(got.size()));
    end
  endtask
  task automatic t_phy();
    xfer('{32'h1234_5678}, 1'h1, 4);
    chk("count", 32'h4, 32'(got.size()));
    chk("phy hdr", 32'h0000_00E0, got[0]);
    chk("phy data", 32'h1234_5678, got[1]);
    chk("phy inv", 32'hEDCB_A987, got[2]);
    chk("phy trl", trl(), got[3]);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'h1;
    repeat (2) @(negedge i_clk);
    t_qread();
    t_qwrite();
    ctl = 16'h0421;
    cyc = 13'h0003;
    t_bread();
    t_block();
    t_lock();
    t_resp();
    t_drop();
    t_phy();
    summarize();
  end
endmodule // async_receive_request_formatter_bench
`default_nettype wire

// File: verilog/arf_formatter.sv
// Asynchronous receive formatter: link quadlets in, host buffer quadlets out
// ==========================================================
// What this block does
// - Drop packets with undefined transaction codes
// - Sort packets into four storage layouts
// - Target node ID is 16 bits
// - Keep 6-bit transaction label in header
// - Store 2-bit retry code unchanged
// - Copy reserved bits untouched
// - Sender node ID is 16 bits
// - Offset is 16 upper plus 32 lower
// - Store response code as received
// - First payload byte in top byte
// - Accept pad bytes, whole quadlets stored
// - Trailer: status word high, cycle mark low
// - Quadlet read request stored as four quadlets
// - Quadlet write request stored as five quadlets
// - Block read request stored as five quadlets
// - Block write/lock: header, count, payload, trailer
// - Lock operation code zero unless lock: kept as sent, not zeroed here
// - PHY packet: header, quadlet, inverse, trailer
`timescale 1ns/1ps
`default_nettype none

module arf_formatter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic i_rx_phy,
  output logic o_rx_ready,
  input wire logic [15:0] i_dma_channel_control,
  input wire logic [6:0] i_bus_seconds_count,
  input wire logic [12:0] i_bus_cycle_index,
  output logic o_buf_valid,
  output logic [31:0] o_buf_data,
  output logic o_buf_first,
  output logic o_buf_last,
  output logic o_pkt_dropped
);

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    ARF_ST_IDLE = 3'b000,
    ARF_ST_BODY = 3'b001,
    ARF_ST_INV = 3'b011,
    ARF_ST_TRAIL = 3'b010,
    ARF_ST_DROP = 3'b110
  } arf_state_e;

  arf_state_e state_q, state_d;
  arf_pkg::arf_fmt_e fmt_q, fmt_d;
  logic [2:0] quad_idx_q, quad_idx_d;
  logic [31:0] phy_q, phy_d;
  logic [15:0] mark_q, mark_d;
  logic buf_valid_q, buf_valid_d;
  logic [31:0] buf_data_q, buf_data_d;
  logic buf_first_q, buf_first_d;
  logic buf_last_q, buf_last_d;
  logic dropped_q, dropped_d;
  logic ready_q, ready_d;
  logic cls_defined;
  arf_pkg::arf_fmt_e cls_fmt;
  logic [2:0] cls_quads;
  logic [3:0] hdr_tcode;
  logic take;
  logic [2:0] fixed_quads_q, fixed_quads_d;
  logic resp_q, resp_d;
  logic [15:0] hdr_target_node_id;
  logic [5:0] hdr_transaction_label;
  logic [1:0] hdr_retry_code;
  logic [3:0] hdr_reserved;

  assign hdr_tcode = i_rx_data[arf_pkg::TCODE_LSB +: arf_pkg::TCODE_W];
  assign take = i_rx_valid & ready_q;

  // ==========================================================
  // Header fields
  assign hdr_target_node_id = i_rx_data[arf_pkg::TARGET_ID_LSB +: arf_pkg::TARGET_ID_W];
  assign hdr_transaction_label = i_rx_data[arf_pkg::LABEL_LSB +: arf_pkg::LABEL_W];
  assign hdr_retry_code = i_rx_data[arf_pkg::RETRY_LSB +: arf_pkg::RETRY_W];
  assign hdr_reserved = i_rx_data[arf_pkg::HDR_RSVD_LSB +: arf_pkg::HDR_RSVD_W];

  arf_tcode_class u_class (
    .i_tcode(hdr_tcode),
    .o_defined(cls_defined),
    .o_fmt(cls_fmt),
    .o_fixed_quads(cls_quads)
  );

  // Trailer composed once so both paths agree
  function automatic logic [31:0] trailer_word(input logic [15:0] status,
                                               input logic [15:0] mark);
    trailer_word = {status, mark};
  endfunction

  // Response codes sit where request offsets sit; the layout cannot tell them apart
  function automatic logic is_response(input logic [3:0] tcode);
    is_response = (tcode == arf_pkg::TC_WRITE_RESP) || (tcode == arf_pkg::TC_QREAD_RESP) ||
                  (tcode == arf_pkg::TC_BREAD_RESP) || (tcode == arf_pkg::TC_LOCK_RESP);
  endfunction

  // Header rebuilt from its fields; reserved bits ride along unchecked
  function automatic logic [31:0] header_word(input logic [15:0] target,
                                              input logic [5:0] label,
                                              input logic [1:0] retry,
                                              input logic [3:0] tcode,
                                              input logic [3:0] rsvd);
    header_word = {target, label, retry, tcode, rsvd};
  endfunction

  // Body quadlets rebuilt by field for the layout in hand. Nothing is masked
  // or realigned, so a malformed sender value reaches software as sent
  function automatic logic [31:0] body_word(input arf_pkg::arf_fmt_e fmt,
                                            input logic resp,
                                            input logic [2:0] idx,
                                            input logic [2:0] fixed,
                                            input logic [31:0] data);
    logic [15:0] upper;
    logic [15:0] lower;
    upper = data[arf_pkg::HALF_W +: arf_pkg::HALF_W];
    lower = data[arf_pkg::HALF_W-1:0];
    body_word = data;
    if (idx >= fixed) begin
      // Payload in bus byte order, first byte on top; pad bytes kept whole
      body_word = data;
    end else begin
      case (idx)
        arf_pkg::QIDX_SENDER: begin
          if (resp) begin
            body_word = {upper, data[arf_pkg::RESP_CODE_LSB +: arf_pkg::RESP_CODE_W],
                         data[arf_pkg::RESP_CODE_LSB-1:0]};
          end else begin
            body_word = {upper, lower};
          end
        end
        arf_pkg::QIDX_OFFSET_LOWER: begin
          body_word = data;
        end
        arf_pkg::QIDX_FOURTH: begin
          // Lock code kept as sent: a non-lock sender is the one to zero it
          if (fmt == arf_pkg::ARF_FMT_BLOCK) begin
            body_word = {upper, lower};
          end else begin
            body_word = data;
          end
        end
        default: begin
          body_word = data;
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    fmt_d = fmt_q;
    quad_idx_d = quad_idx_q;
    phy_d = phy_q;
    buf_valid_d = 1'b0;
    buf_data_d = buf_data_q;
    buf_first_d = 1'b0;
    buf_last_d = 1'b0;
    dropped_d = 1'b0;
    ready_d = ready_q;
    case (state_q)
      ARF_ST_IDLE: begin
        ready_d = 1'b1;
        if (take) begin
          quad_idx_d = arf_pkg::QIDX_BODY_FIRST;
          if (i_rx_phy) begin
            // Synthesized header; the PHY quadlet itself follows
            fmt_d = arf_pkg::ARF_FMT_PHY;
            phy_d = i_rx_data;
            buf_valid_d = 1'b1;
            buf_first_d = 1'b1;
            buf_data_d = {arf_pkg::PHY_HDR_FILL, arf_pkg::TC_PHY, arf_pkg::PHY_HDR_LOW};
            // Header write stalls the link for the data, inverse and trailer
            ready_d = 1'b0;
            state_d = ARF_ST_INV;
          end else if (!cls_defined || cls_fmt == arf_pkg::ARF_FMT_PHY) begin
            // Nothing is written for an unknown code; swallow the rest
            dropped_d = 1'b1;
            state_d = i_rx_last ? ARF_ST_IDLE : ARF_ST_DROP;
          end else begin
            // Whole header quadlet passes bit for bit: ids, label, retry,
            // code and reserved bits all stay where the sender put them
            fmt_d = cls_fmt;
            buf_valid_d = 1'b1;
            buf_first_d = 1'b1;
            buf_data_d = header_word(hdr_target_node_id, hdr_transaction_label,
                                     hdr_retry_code, hdr_tcode,
                                     hdr_reserved);
            state_d = i_rx_last ? ARF_ST_TRAIL : ARF_ST_BODY;
            if (i_rx_last) begin
              ready_d = 1'b0;
            end
          end
        end
      end
      ARF_ST_BODY: begin
        if (take) begin
          // Sender id, offsets, response code, count and lock code copied
          // unchanged; pad bytes are already whole quadlets
          buf_valid_d = 1'b1;
          buf_data_d = body_word(fmt_q, resp_q, quad_idx_q, fixed_quads_q,
                                 i_rx_data);
          if (quad_idx_q != arf_pkg::QIDX_MAX) begin
            quad_idx_d = quad_idx_q + arf_pkg::QIDX_STEP;
          end
          if (i_rx_last) begin
            ready_d = 1'b0;
            state_d = ARF_ST_TRAIL;
          end
        end
      end
      ARF_ST_INV: begin
        // Data quadlet then its inverse, one per cycle
        buf_valid_d = 1'b1;
        if (quad_idx_q == arf_pkg::QIDX_PHY_DATA) begin
          buf_data_d = phy_q;
          quad_idx_d = arf_pkg::QIDX_PHY_INV;
        end else begin
          buf_data_d = ~phy_q;
          state_d = ARF_ST_TRAIL;
        end
      end
      ARF_ST_TRAIL: begin
        buf_valid_d = 1'b1;
        buf_last_d = 1'b1;
        buf_data_d = trailer_word(i_dma_channel_control, mark_q);
        ready_d = 1'b1;
        state_d = ARF_ST_IDLE;
      end
      ARF_ST_DROP: begin
        if (take && i_rx_last) begin
          state_d = ARF_ST_IDLE;
        end
      end
      default: begin
        state_d = ARF_ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ARF_ST_IDLE;
      fmt_q <= arf_pkg::ARF_FMT_NODATA;
      quad_idx_q <= 3'h0;
      phy_q <= 32'h0000_0000;
      buf_valid_q <= 1'b0;
      buf_data_q <= 32'h0000_0000;
      buf_first_q <= 1'b0;
      buf_last_q <= 1'b0;
      dropped_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fmt_q <= fmt_d;
      quad_idx_q <= quad_idx_d;
      phy_q <= phy_d;
      buf_valid_q <= buf_valid_d;
      buf_data_q <= buf_data_d;
      buf_first_q <= buf_first_d;
      buf_last_q <= buf_last_d;
      dropped_q <= dropped_d;
      ready_q <= ready_d;
    end
  end

  // ==========================================================
  // Layout bookkeeping
  // Only the header quadlet moves it, so body quadlets see a steady layout
  always_comb begin
    fixed_quads_d = fixed_quads_q;
    resp_d = resp_q;
    if (state_q == ARF_ST_IDLE && take && !i_rx_phy) begin
      fixed_quads_d = cls_quads;
      resp_d = is_response(hdr_tcode);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fixed_quads_q <= arf_pkg::HDR_QUADS_NODATA;
      resp_q <= 1'b0;
    end else begin
      fixed_quads_q <= fixed_quads_d;
      resp_q <= resp_d;
    end
  end

  // ==========================================================
  // Cycle mark
  // Taken with the header quadlet, which lies inside reception
  always_comb begin
    mark_d = mark_q;
    if (state_q == ARF_ST_IDLE && take) begin
      mark_d = {i_bus_seconds_count[arf_pkg::SECONDS_KEEP_W-1:0],
                i_bus_cycle_index};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mark_q <= 16'h0000;
    end else begin
      mark_q <= mark_d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rx_ready = ready_q;
  assign o_buf_valid = buf_valid_q;
  assign o_buf_data = buf_data_q;
  assign o_buf_first = buf_first_q;
  assign o_buf_last = buf_last_q;
  assign o_pkt_dropped = dropped_q;

endmodule // arf_formatter

`default_nettype wire

// File: verilog/arf_tcode_class.sv
// Transaction code classifier for the receive formatter
`timescale 1ns/1ps
`default_nettype none

module arf_tcode_class (
  input wire logic [3:0] i_tcode,
  output logic o_defined,
  output arf_pkg::arf_fmt_e o_fmt,
  output logic [2:0] o_fixed_quads
);

  // ==========================================================
  // Classification
  always_comb begin
    o_defined = 1'b1;
    o_fmt = arf_pkg::ARF_FMT_NODATA;
    o_fixed_quads = arf_pkg::HDR_QUADS_NODATA;
    case (i_tcode)
      arf_pkg::TC_QREAD_REQ, arf_pkg::TC_WRITE_RESP: begin
        o_fmt = arf_pkg::ARF_FMT_NODATA;
        o_fixed_quads = arf_pkg::HDR_QUADS_NODATA;
      end
      arf_pkg::TC_QWRITE_REQ, arf_pkg::TC_QREAD_RESP, arf_pkg::TC_BREAD_REQ: begin
        o_fmt = arf_pkg::ARF_FMT_QUAD;
        o_fixed_quads = arf_pkg::HDR_QUADS_QUAD;
      end
      arf_pkg::TC_BWRITE_REQ, arf_pkg::TC_BREAD_RESP, arf_pkg::TC_LOCK_REQ,
      arf_pkg::TC_LOCK_RESP: begin
        o_fmt = arf_pkg::ARF_FMT_BLOCK;
        o_fixed_quads = arf_pkg::HDR_QUADS_BLOCK;
      end
      arf_pkg::TC_PHY: begin
        o_fmt = arf_pkg::ARF_FMT_PHY;
        o_fixed_quads = arf_pkg::HDR_QUADS_PHY;
      end
      default: begin
        o_defined = 1'b0;
      end
    endcase
  end

endmodule // arf_tcode_class

`default_nettype wire
